//--- rtl/wsc_channel.sv
// Half-duplex word serial channel: 22-bit frames of 20-bit words.
// Assumes host strobes are one-cycle pulses on sys_clk_i; line input is asynchronous.
`timescale 1ns/1ns
module wsc_channel #(
    parameter logic PAR_ODD = 1'b1,
    parameter logic PAR_COVER_CB1 = 1'b1
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // Speed setting, a strap-like level
    input wire logic [2:0] speed_i,
    // External function and status test
    input wire logic drive_external_function_i,
    input wire logic [3:0] function_code_i,
    input wire logic external_status_test_i,
    input wire logic [3:0] status_code_i,
    output logic status_o,
    // Register transfers
    input wire logic register_transfer_rd_i,
    output logic [17:0] rd_data_o,
    output logic rd_valid_o,
    input wire logic register_transfer_wr_i,
    input wire logic [17:0] wr_data_i,
    // Control flip-flops
    output logic cb1_o,
    output logic cb3_o,
    // Serial line
    input wire logic line_rx_i,
    output logic line_tx_o,
    output logic carrier_o
);
    typedef struct packed {
        logic [1:0] rx_sync;
        wsc_pkg::wsc_rx_state_t rx_state;
        logic [17:0] rx_cnt;
        logic [4:0] rx_bits;
        logic [21:0] rx_shift;
        logic [19:0] rx_hold;
        logic rx_flag;
        logic [19:0] tx_hold;
        logic tx_flag;
        logic tx_mode;
        logic [20:0] tx_shift;
        logic [4:0] tx_left;
        logic [17:0] tx_cnt;
        logic line_tx;
        logic status;
        logic [17:0] rd_data;
        logic rd_valid;
        logic cb1;
        logic cb3;
    } wsc_st_t;

    wsc_st_t st_reg, st_next;
    logic buf_in_ready, buf_out_valid;
    logic [19:0] buf_out_data;
    logic [17:0] bit_cycles, half_bit;
    logic rx_step, tx_step, rx_done;

    // Bit period in cycles for a speed code
    function automatic logic [17:0] period_of(input logic [2:0] spd);
        unique case (spd)
            wsc_pkg::SPD_600: period_of = wsc_pkg::BIT_600;
            wsc_pkg::SPD_1200: period_of = wsc_pkg::BIT_1200;
            wsc_pkg::SPD_1800: period_of = wsc_pkg::BIT_1800;
            wsc_pkg::SPD_2000: period_of = wsc_pkg::BIT_2000;
            wsc_pkg::SPD_2400: period_of = wsc_pkg::BIT_2400;
            wsc_pkg::SPD_3000: period_of = wsc_pkg::BIT_3000;
            default: period_of = wsc_pkg::BIT_600;
        endcase
    endfunction

    // Word parity over bits 1-18 and optionally bit 19
    function automatic logic parity_of(input logic [17:0] d, input logic c1);
        parity_of = (^d) ^ (PAR_COVER_CB1 & c1) ^ PAR_ODD;
    endfunction

    // Transmit word: parity on top, then control bit one, then the host's 18 bits
    function automatic logic [19:0] tx_word_of(input logic [17:0] d, input logic c1);
        tx_word_of = {parity_of(d, c1), c1, d};
    endfunction

    assign bit_cycles = period_of(speed_i);
    // Odd periods round down, so a start bit qualifies at most one cycle early
    assign half_bit = bit_cycles >> 1;

    // One receiver sample and one transmitter step per bit period
    assign rx_step = st_reg.rx_cnt == 18'(bit_cycles - 18'h00001);
    assign tx_step = st_reg.tx_cnt == 18'h00000;
    // The last sample is the stop bit; the word is whole at that point
    assign rx_done = st_reg.rx_state == wsc_pkg::RX_SHIFT && rx_step
        && st_reg.rx_bits == 5'(wsc_pkg::FRAME_BITS - 1);

    // Finished words pass a two-entry buffer; the hold register always drains it,
    // so a slow host never stalls the shifter
    wsc_skid u_skid (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .in_valid_i(rx_done && buf_in_ready),
        .in_ready_o(buf_in_ready),
        .in_data_i(st_reg.rx_shift[21:2]),
        .out_valid_o(buf_out_valid),
        .out_ready_i(1'b1),
        .out_data_o(buf_out_data)
    );

    always_comb begin
        st_next = st_reg;
        st_next.rx_sync = {st_reg.rx_sync[0], line_rx_i};
        st_next.rd_valid = 1'b0;

        // Receiver
        unique case (st_reg.rx_state)
            wsc_pkg::RX_IDLE: begin
                st_next.rx_cnt = 18'h00000;
                if (st_reg.rx_sync[1] != wsc_pkg::MARK) begin
                    st_next.rx_state = wsc_pkg::RX_QUAL;
                end
            end
            wsc_pkg::RX_QUAL: begin
                // Noise shorter than half a bit is dropped
                if (st_reg.rx_sync[1] == wsc_pkg::MARK) begin
                    st_next.rx_state = wsc_pkg::RX_IDLE;
                end else if (st_reg.rx_cnt >= half_bit) begin
                    // Mid start bit: shift it in, time the rest from here
                    st_next.rx_state = wsc_pkg::RX_SHIFT;
                    st_next.rx_cnt = 18'h00000;
                    st_next.rx_shift = {st_reg.rx_sync[1], 21'h000000};
                    st_next.rx_bits = 5'h01;
                end else begin
                    st_next.rx_cnt = 18'(st_reg.rx_cnt + 18'h00001);
                end
            end
            wsc_pkg::RX_SHIFT: begin
                if (rx_step) begin
                    st_next.rx_cnt = 18'h00000;
                    st_next.rx_shift = {st_reg.rx_sync[1], st_reg.rx_shift[21:1]};
                    st_next.rx_bits = 5'(st_reg.rx_bits + 5'h01);
                    if (rx_done) begin
                        // Full: word goes to the buffer, timer stops until the next start bit
                        st_next.rx_state = wsc_pkg::RX_IDLE;
                    end
                end else begin
                    st_next.rx_cnt = 18'(st_reg.rx_cnt + 18'h00001);
                end
            end
            default: st_next.rx_state = wsc_pkg::RX_IDLE;
        endcase

        // Host read returns the word split over three destinations
        if (register_transfer_rd_i) begin
            st_next.rd_data = st_reg.rx_hold[wsc_pkg::HOST_W-1:0];
            st_next.cb1 = st_reg.rx_hold[wsc_pkg::CB1_POS];
            st_next.cb3 = st_reg.rx_hold[wsc_pkg::CB3_POS];
            st_next.rd_valid = 1'b1;
            st_next.rx_flag = 1'b0;
            st_next.rx_hold = wsc_pkg::WORD_RST;
        end

        // Host write assembles bits 19 and 20 in hardware
        if (register_transfer_wr_i) begin
            st_next.tx_hold = tx_word_of(wr_data_i, st_reg.cb1);
            st_next.tx_flag = 1'b0;
        end

        // External functions; codes 5-15 and 0 do nothing
        if (drive_external_function_i) begin
            unique case (function_code_i)
                wsc_pkg::FN_CLR_RX: begin
                    st_next.rx_flag = 1'b0;
                    st_next.rx_hold = wsc_pkg::WORD_RST;
                end
                wsc_pkg::FN_CLR_TX: begin
                    st_next.tx_flag = 1'b0;
                    st_next.tx_hold = wsc_pkg::WORD_RST;
                end
                wsc_pkg::FN_RX_MODE: st_next.tx_mode = 1'b0;
                wsc_pkg::FN_TX_MODE: st_next.tx_mode = 1'b1;
                default: st_next.tx_mode = st_reg.tx_mode;
            endcase
        end

        // A buffered word lands even over an unread one; the set wins over a same-cycle clear
        if (buf_out_valid) begin
            st_next.rx_flag = 1'b1;
            st_next.rx_hold = buf_out_data;
        end

        // Receive mode cuts a frame short: the half-duplex line goes back to mark
        if (!st_reg.tx_mode) begin
            st_next.line_tx = wsc_pkg::MARK;
            st_next.tx_left = 5'h00;
            st_next.tx_cnt = 18'h00000;
        end else if (!tx_step) begin
            // Transmitter bit timer
            st_next.tx_cnt = 18'(st_reg.tx_cnt - 18'h00001);
        end else if (st_reg.tx_left != 5'h00) begin
            st_next.line_tx = st_reg.tx_shift[0];
            st_next.tx_shift = {wsc_pkg::MARK, st_reg.tx_shift[20:1]};
            st_next.tx_left = 5'(st_reg.tx_left - 5'h01);
            st_next.tx_cnt = 18'(bit_cycles - 18'h00001);
        end else if (!st_reg.tx_flag) begin
            // Load word: start bit now, 20 bits and stop bit follow
            st_next.line_tx = ~wsc_pkg::MARK;
            st_next.tx_shift = {wsc_pkg::MARK, st_reg.tx_hold};
            st_next.tx_left = 5'(wsc_pkg::FRAME_BITS - 1);
            st_next.tx_cnt = 18'(bit_cycles - 18'h00001);
            st_next.tx_flag = 1'b1;
        end else begin
            // Flag still set: hold stop bits until the host writes
            st_next.line_tx = wsc_pkg::MARK;
        end

        // Status test answer
        st_next.status = 1'b0;
        if (external_status_test_i) begin
            if (status_code_i == wsc_pkg::ST_RX_FLAG) begin
                st_next.status = st_reg.rx_flag;
            end else if (status_code_i == wsc_pkg::ST_TX_FLAG) begin
                st_next.status = st_reg.tx_flag;
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            st_reg <= '0;
            st_reg.rx_sync <= 2'h3;
            st_reg.line_tx <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    assign status_o = st_reg.status;
    assign rd_data_o = st_reg.rd_data;
    assign rd_valid_o = st_reg.rd_valid;
    assign cb1_o = st_reg.cb1;
    assign cb3_o = st_reg.cb3;
    assign line_tx_o = st_reg.line_tx;
    assign carrier_o = st_reg.tx_mode;
endmodule

//--- rtl/wsc_pkg.sv
// Constants and types for the half-duplex word serial channel.
// Assumes a 100 MHz system clock; line rates are derived from it.
package wsc_pkg;

    localparam int unsigned CLK_HZ = 100000000;
    localparam int unsigned WORD_W = 20;
    localparam int unsigned HOST_W = 18;
    localparam int unsigned FRAME_BITS = 22;

    // Line rates in bits per second, indexed by the speed setting
    localparam int unsigned RATE_600 = 600;
    localparam int unsigned RATE_1200 = 1200;
    localparam int unsigned RATE_1800 = 1800;
    localparam int unsigned RATE_2000 = 2000;
    localparam int unsigned RATE_2400 = 2400;
    localparam int unsigned RATE_3000 = 3000;

    // Speed setting codes
    localparam logic [2:0] SPD_600 = 3'h0;
    localparam logic [2:0] SPD_1200 = 3'h1;
    localparam logic [2:0] SPD_1800 = 3'h2;
    localparam logic [2:0] SPD_2000 = 3'h3;
    localparam logic [2:0] SPD_2400 = 3'h4;
    localparam logic [2:0] SPD_3000 = 3'h5;

    // Bit period in clock cycles, rounded down
    localparam logic [17:0] BIT_600 = 18'(CLK_HZ / RATE_600);
    localparam logic [17:0] BIT_1200 = 18'(CLK_HZ / RATE_1200);
    localparam logic [17:0] BIT_1800 = 18'(CLK_HZ / RATE_1800);
    localparam logic [17:0] BIT_2000 = 18'(CLK_HZ / RATE_2000);
    localparam logic [17:0] BIT_2400 = 18'(CLK_HZ / RATE_2400);
    localparam logic [17:0] BIT_3000 = 18'(CLK_HZ / RATE_3000);

    // External-function command codes
    localparam logic [3:0] FN_CLR_RX = 4'h1;
    localparam logic [3:0] FN_CLR_TX = 4'h2;
    localparam logic [3:0] FN_RX_MODE = 4'h3;
    localparam logic [3:0] FN_TX_MODE = 4'h4;

    // Status test codes
    localparam logic [3:0] ST_RX_FLAG = 4'h1;
    localparam logic [3:0] ST_TX_FLAG = 4'h2;

    // Field positions inside a 20-bit word (bit n of the word is index n-1)
    localparam int unsigned CB1_POS = 18;
    localparam int unsigned CB3_POS = 19;

    // Reset values
    localparam logic [WORD_W-1:0] WORD_RST = 20'h00000;
    localparam logic MARK = 1'b1;

    typedef enum logic [1:0] {
        RX_IDLE = 2'b00,
        RX_QUAL = 2'b01,
        RX_SHIFT = 2'b11
    } wsc_rx_state_t;

endpackage

//--- rtl/wsc_skid.sv
// Two-entry buffer with valid and ready on both sides.
// Assumes source and sink on sys_clk_i; output data comes from a register.
`timescale 1ns/1ns
module wsc_skid (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // Filling side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [19:0] in_data_i,
    // Draining side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [19:0] out_data_o
);
    typedef struct packed {
        logic [1:0][19:0] mem;
        logic [1:0] count;
        logic rd;
        logic wr;
    } wsc_skid_st_t;

    wsc_skid_st_t st_reg, st_next;
    logic push, pop;

    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;
    assign in_ready_o = st_reg.count != 2'h2;
    assign out_valid_o = st_reg.count != 2'h0;
    assign out_data_o = st_reg.mem[st_reg.rd];

    always_comb begin
        st_next = st_reg;
        if (push) begin
            st_next.mem[st_reg.wr] = in_data_i;
            st_next.wr = ~st_reg.wr;
        end
        if (pop) begin
            st_next.rd = ~st_reg.rd;
        end
        st_next.count = 2'(st_reg.count + {1'b0, push} - {1'b0, pop});
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end
endmodule

//--- sim/wsc_monitor.sv
// Port assertions for the word serial channel.
// Assumes a bind from the bench top and one clock domain.
`timescale 1ns/1ns
module wsc_monitor (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // Host side
    input wire logic drive_external_function_i,
    input wire logic [3:0] function_code_i,
    input wire logic external_status_test_i,
    input wire logic [3:0] status_code_i,
    input wire logic status_o,
    input wire logic register_transfer_rd_i,
    input wire logic [17:0] rd_data_o,
    input wire logic rd_valid_o,
    input wire logic cb1_o,
    input wire logic cb3_o,
    // Line side
    input wire logic line_tx_o,
    input wire logic carrier_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    sequence s_tx_cmd;
        drive_external_function_i && function_code_i == 4'h4 && !carrier_o;
    endsequence
    sequence s_tx_start;
        carrier_o ##1 !line_tx_o;
    endsequence
    AST_TX_START: assert property (s_tx_cmd |=> s_tx_start)
        else $error("no carrier or start bit after transmit command");
    AST_RST_IDLE: assert property (disable iff (1'b0) rst_i |=> line_tx_o && !carrier_o)
        else $error("line not idle after reset");
    AST_RX_MODE: assert property (drive_external_function_i && function_code_i == 4'h3 |=> !carrier_o)
        else $error("carrier still up after receive command");
    AST_CARRIER_HOLD: assert property (!(drive_external_function_i && function_code_i inside {4'h3, 4'h4})
        |=> $stable(carrier_o))
        else $error("carrier moved without a mode command");
    AST_STATUS_IDLE: assert property (!external_status_test_i |=> !status_o)
        else $error("status raised without a test");
    AST_STATUS_UNUSED: assert property (external_status_test_i && !(status_code_i inside {4'h1, 4'h2})
        |=> !status_o)
        else $error("unused status test answered");
    AST_RD_PULSE: assert property (1'b1 |=> rd_valid_o == $past(register_transfer_rd_i))
        else $error("read answer not one cycle after strobe");
    AST_HOLD_READ: assert property (!register_transfer_rd_i |=> $stable({rd_data_o, cb1_o, cb3_o}))
        else $error("read outputs changed without a read");
    AST_RX_IDLE_MARK: assert property (!carrier_o [*2] |-> line_tx_o)
        else $error("line not at mark in receive mode");
endmodule

//--- sim/wsc_remote.sv
// Remote processor on the serial line.
// Assumes its task is called just after a clock edge.
`timescale 1ns/1ns
module wsc_remote (
    // Clock
    input wire logic sys_clk_i,
    // Line
    input wire logic line_tx_i,
    output logic line_rx_o
);
    initial line_rx_o = 1'b1; // Idle at mark
    // Short space, a noise hit the far receiver must ignore
    task automatic space_pulse(input int n);
        line_rx_o = 1'b0;
        repeat (n) @(posedge sys_clk_i);
        #1 line_rx_o = 1'b1;
    endtask
endmodule

//--- sim/testbench.sv
// Self-checking bench for the word serial channel.
// Assumes 100 MHz; a frame lasts far too long, so only frame starts are watched.
`timescale 1ns/1ns
module testbench;
    logic sys_clk, rst, dxf, est, rd, wr, cb1, cb3, st_o, rdv, tx, rx, car;
    logic [3:0] fc, sc;
    logic [2:0] spd;
    logic [17:0] wd, rdd;
    logic [17:0] m_rxq[$];
    int num_errors, comparisons, cycles, m_car, m_txf;
    wsc_channel u_dut (.sys_clk_i(sys_clk), .rst_i(rst), .speed_i(spd), .drive_external_function_i(dxf),
        .function_code_i(fc), .external_status_test_i(est), .status_code_i(sc), .status_o(st_o),
        .register_transfer_rd_i(rd), .rd_data_o(rdd), .rd_valid_o(rdv), .register_transfer_wr_i(wr),
        .wr_data_i(wd), .cb1_o(cb1), .cb3_o(cb3), .line_rx_i(rx), .line_tx_o(tx), .carrier_o(car));
    wsc_remote u_rem (.sys_clk_i(sys_clk), .line_tx_i(tx), .line_rx_o(rx));
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    task automatic end_sim();
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic tick(input int n = 1);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic chk(input logic [17:0] got, input logic [17:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic func(input logic [3:0] c);
        dxf = 1'b1;
        fc = c;
        tick();
        dxf = 1'b0;
        if (c == 4'h3) m_car = 0;
        if (c == 4'h4) m_car = 1;
        // Written word is loaded at once, so the flag sets
        if (c == 4'h4) m_txf = 1;
        if (c == 4'h2) m_txf = 0;
        if (c == 4'h1) m_rxq.delete();
        tick();
    endtask
    task automatic stat(input logic [3:0] c);
        est = 1'b1;
        sc = c;
        tick();
        est = 1'b0;
        chk(18'(st_o), 18'(c == 4'h2 ? m_txf : (c == 4'h1 ? m_rxq.size() > 0 : 0)));
        tick();
    endtask
    task automatic read_word();
        logic [17:0] e;
        e = m_rxq.size() > 0 ? m_rxq.pop_front() : 18'h00000;
        rd = 1'b1;
        tick();
        rd = 1'b0;
        chk(18'(rdv), 18'h00001);
        chk(rdd, e);
        chk(18'({cb3, cb1}), 18'h00000);
        tick();
    endtask
    task automatic write_word(input logic [17:0] d);
        wr = 1'b1;
        wd = d;
        tick();
        wr = 1'b0;
        m_txf = 0;
        tick();
    endtask
    initial begin
        {dxf, est, rd, wr, fc, sc, wd} = '0;
        spd = 3'h5;
        rst = 1'b1;
        m_car = 0;
        m_txf = 0;
        void'($urandom(32'h7bc580e1));
        tick(10);
        rst = 1'b0;
        chk(18'({tx, car}), 18'h00002);
        for (int c = 0; c < 16; c++) stat(4'(c));
        for (int c = 15; c >= 0; c--) begin
            if (c != 4) func(4'(c));
            chk(18'(car), 18'(m_car));
        end
        read_word();
        u_rem.space_pulse(16000);
        stat(4'h1);
        // Slower rate: its start bit outlasts a whole bit at the faster rate
        spd = 3'h4;
        write_word({17'($urandom), 1'b1});
        func(4'h4);
        tick();
        chk(18'({tx, car}), 18'h00001);
        stat(4'h2);
        // Refill long before the frame ends, so no idle gap
        write_word(18'($urandom));
        stat(4'h2);
        tick(35000);
        chk(18'(tx), 18'h00000);
        tick(15000);
        chk(18'(tx), 18'h00001);
        func(4'h3);
        tick();
        chk(18'({tx, car}), 18'h00002);
        func(4'h1);
        stat(4'h1);
        read_word();
        end_sim();
    end
    // Run needs about 66k cycles
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 100000) begin
            num_errors++;
            $display("mismatch at %0t: run too long", $time);
            end_sim();
        end
    end
endmodule
bind wsc_channel wsc_monitor u_mon (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .drive_external_function_i(drive_external_function_i), .function_code_i(function_code_i),
    .external_status_test_i(external_status_test_i), .status_code_i(status_code_i), .status_o(status_o),
    .register_transfer_rd_i(register_transfer_rd_i), .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o),
    .cb1_o(cb1_o), .cb3_o(cb3_o), .line_tx_o(line_tx_o), .carrier_o(carrier_o));
